// ==== verilog/bcc_top.sv ====
// bus command control output stage: cycle decode, bus states, strobes and transceiver control
`timescale 1ns/1ps
module bcc_top (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // strap and cycle inputs
    input  wire logic compat_timing_select,
    input  wire logic space_select,
    input  wire logic status_hi_n,
    input  wire logic status_lo_n,
    input  wire logic controller_select_latched,
    input  wire logic command_hold_off,
    input  wire logic ready_n,
    input  wire logic gate_or_grant_pin,
    // command strobes, value and output enable
    output logic      io_write_strobe_n,
    output logic      io_read_strobe_n,
    output logic      mem_write_strobe_n,
    output logic      mem_read_strobe_n,
    output logic      irq_ack_strobe_n,
    output logic      cmd_oe,
    // control outputs
    output logic      addr_latch_strobe,
    output logic      cascade_addr_gate,
    output logic      xcvr_on,
    output logic      xcvr_dir
);

    // ------------------------------------------------------------
    // enable pin synchroniser
    // ------------------------------------------------------------
    logic pin_level;
    logic pin_sync;

    // fold the pin so that a cleared synchroniser reads as closed in both modes,
    // otherwise a denied grant would look granted for two clocks after reset
    assign pin_level = compat_timing_select ? ~gate_or_grant_pin : gate_or_grant_pin;

    bcc_sync #(
        .STAGES (bcc_pkg::SYNC_STAGES)
    ) u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .d_async (pin_level),
        .q_sync  (pin_sync)
    );

    // meaning of the pin follows the timing strap
    logic cmd_gate;
    logic shared_bus_grant_n;
    logic permit;
    assign cmd_gate           = ~compat_timing_select & pin_sync;
    assign shared_bus_grant_n = compat_timing_select ? ~pin_sync : 1'b0;
    assign permit             = compat_timing_select ? ~shared_bus_grant_n : cmd_gate;

    // ------------------------------------------------------------
    // cycle decode
    // ------------------------------------------------------------
    function automatic logic cyc_active(input logic [2:0] c);
        return (c[1:0] != 2'h3) && (c != bcc_pkg::CYC_HALT);
    endfunction

    function automatic logic cyc_write(input logic [2:0] c);
        return (c == bcc_pkg::CYC_IO_WR) || (c == bcc_pkg::CYC_MEM_WR);
    endfunction

    function automatic logic [4:0] strobe_of(input logic [2:0] c);
        logic [4:0] s;
        s = bcc_pkg::STROBE_IDLE;
        case (c)
            bcc_pkg::CYC_IO_WR:  s[4] = 1'b0;
            bcc_pkg::CYC_IO_RD:  s[3] = 1'b0;
            bcc_pkg::CYC_MEM_WR: s[2] = 1'b0;
            bcc_pkg::CYC_MEM_RD: s[1] = 1'b0;
            bcc_pkg::CYC_ACK:    s[0] = 1'b0;
            default:             s    = bcc_pkg::STROBE_IDLE;
        endcase
        return s;
    endfunction

    logic [2:0] cyc_in;
    logic       start;
    assign cyc_in = {space_select, status_hi_n, status_lo_n};
    assign start  = ~(status_hi_n & status_lo_n);

    // the phase flag is a single bit, so a bus state cannot span other than two clocks
    if (bcc_pkg::PHASES_PER_STATE != 2) begin : g_phase_check
        $error("bus states must span two clocks");
    end

    // ------------------------------------------------------------
    // bus state machine
    // ------------------------------------------------------------
    bcc_pkg::bcc_state_t state_r;
    bcc_pkg::bcc_state_t state_nxt;
    logic                phase_r;      // second clock of a bus state
    logic                phase_nxt;
    logic [2:0]          cyc_r;
    logic [2:0]          cyc_nxt;
    logic                sel_r;        // latched controller select
    logic                sel_nxt;
    logic                cmd_go_r;     // hold-off released
    logic                cmd_go_nxt;
    logic                waited_r;     // at least one wait state begun
    logic                waited_nxt;

    // next state: each bus state spans two clocks
    always_comb begin
        state_nxt  = state_r;
        phase_nxt  = ~phase_r;
        cyc_nxt    = cyc_r;
        sel_nxt    = sel_r;
        cmd_go_nxt = cmd_go_r;
        waited_nxt = waited_r;
        case (state_r)
            bcc_pkg::ST_IDLE: begin
                phase_nxt = 1'b0;
                if (start) begin
                    state_nxt = bcc_pkg::ST_STATUS;
                    phase_nxt = 1'b1;
                    cyc_nxt   = cyc_in;
                end
            end
            bcc_pkg::ST_STATUS: begin
                if (phase_r) begin
                    sel_nxt    = controller_select_latched;
                    cmd_go_nxt = ~command_hold_off;
                    waited_nxt = 1'b0;
                    state_nxt  = cyc_active(cyc_r) ? bcc_pkg::ST_CMD : bcc_pkg::ST_IDLE;
                end
            end
            bcc_pkg::ST_CMD: begin
                if (!command_hold_off) begin
                    cmd_go_nxt = 1'b1;
                end
                if (phase_r) begin
                    if (ready_n) begin
                        waited_nxt = 1'b1;
                    end else if (start) begin
                        state_nxt = bcc_pkg::ST_STATUS;
                        phase_nxt = 1'b1;
                        cyc_nxt   = cyc_in;
                    end else begin
                        state_nxt = bcc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = bcc_pkg::ST_IDLE;
                phase_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r  <= bcc_pkg::ST_IDLE;
            phase_r  <= 1'b0;
            cyc_r    <= bcc_pkg::CYC_IDLE;
            sel_r    <= 1'b0;
            cmd_go_r <= 1'b0;
            waited_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            phase_r  <= phase_nxt;
            cyc_r    <= cyc_nxt;
            sel_r    <= sel_nxt;
            cmd_go_r <= cmd_go_nxt;
            waited_r <= waited_nxt;
        end
    end

    // ------------------------------------------------------------
    // command qualification
    // ------------------------------------------------------------
    logic in_cmd;
    logic cmd_now;
    logic cmd_live;
    logic want_dir;

    // a strobe needs this controller selected for the cycle
    assign in_cmd   = (state_nxt == bcc_pkg::ST_CMD) && sel_nxt;
    // hold-off is sampled afresh in every status state, so no earlier cycle leaks in
    assign cmd_now  = cmd_go_nxt;
    // compatible timing holds the strobe until the first wait state
    assign cmd_live = in_cmd & cmd_now & (~compat_timing_select | waited_nxt);

    // ------------------------------------------------------------
    // command strobes and their three-state enable
    // ------------------------------------------------------------
    logic [4:0] strobe_r;
    logic [4:0] strobe_nxt;
    logic       oe_r;
    logic       oe_nxt;

    // strobe of the cycle while permitted, forced inactive without grant
    always_comb begin
        strobe_nxt = bcc_pkg::STROBE_IDLE;
        oe_nxt     = ~shared_bus_grant_n;
        if (permit && cmd_live) begin
            strobe_nxt = strobe_of(cyc_nxt);
        end
        if (shared_bus_grant_n) begin
            strobe_nxt = bcc_pkg::STROBE_IDLE;
        end
    end

    // registered so the strobes carry no decode glitches
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            strobe_r <= bcc_pkg::STROBE_IDLE;
            oe_r     <= 1'b0;
        end else begin
            strobe_r <= strobe_nxt;
            oe_r     <= oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // address strobe and cascade gate
    // ------------------------------------------------------------
    logic ale_r;
    logic ale_nxt;
    logic mce_r;
    logic mce_nxt;

    // both ignore every control input
    always_comb begin
        ale_nxt = 1'b0;
        mce_nxt = 1'b0;
        if (state_nxt == bcc_pkg::ST_STATUS && cyc_active(cyc_nxt)) begin
            ale_nxt = phase_nxt;
        end
        if (state_nxt != bcc_pkg::ST_IDLE && cyc_nxt == bcc_pkg::CYC_ACK) begin
            mce_nxt = 1'b1;
        end
    end

    // register the address side controls
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ale_r <= 1'b0;
            mce_r <= 1'b0;
        end else begin
            ale_r <= ale_nxt;
            mce_r <= mce_nxt;
        end
    end

    // ------------------------------------------------------------
    // transceiver enable and direction
    // ------------------------------------------------------------
    logic den_r;
    logic den_nxt;
    logic dir_r;
    logic dir_nxt;

    // direction: reads low, writes and idle high
    assign want_dir = (state_nxt == bcc_pkg::ST_IDLE) || !cyc_active(cyc_nxt) ||
                      cyc_write(cyc_nxt);

    // transceiver opens in the command state once the direction has settled
    always_comb begin
        den_nxt = 1'b0;
        dir_nxt = want_dir;
        if (permit && in_cmd && cyc_active(cyc_nxt)) begin
            // writes in compatible mode wait for the strobe
            den_nxt = (compat_timing_select && cyc_write(cyc_nxt)) ? cmd_live : 1'b1;
        end
        // a direction change closes the transceiver; direction moves once it is closed, a clock later if it was open
        if (want_dir != dir_r) begin
            den_nxt = 1'b0;
        end
        if (den_r) begin
            dir_nxt = dir_r;
        end
        if (shared_bus_grant_n) begin
            den_nxt = 1'b0;
        end
    end

    // register the transceiver controls
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            den_r <= 1'b0;
            dir_r <= bcc_pkg::DIR_IDLE;
        end else begin
            den_r <= den_nxt;
            dir_r <= dir_nxt;
        end
    end

    // drive the pins from the registers
    assign io_write_strobe_n  = strobe_r[4];
    assign io_read_strobe_n   = strobe_r[3];
    assign mem_write_strobe_n = strobe_r[2];
    assign mem_read_strobe_n  = strobe_r[1];
    assign irq_ack_strobe_n   = strobe_r[0];
    assign cmd_oe             = oe_r;
    assign addr_latch_strobe  = ale_r;
    assign cascade_addr_gate  = mce_r;
    assign xcvr_on            = den_r;
    assign xcvr_dir           = dir_r;

endmodule

// ==== verilog/bcc_pkg.sv ====
// package of constants and types for the bus command control output stage
// Functional notes
// - enable pin is active-low grant when timing select high, active-high gate when low
// - grant low takes command outputs out of high impedance, driven inactive high
// - grant high tristates command outputs and holds transceiver enable low
// - short-cycle mode: command gate high permits commands and transceiver enable
// - short-cycle mode: gate low forces inactive levels but keeps outputs driven
// - enable input may be asynchronous; deterministic response when setup/hold met
// - address latch strobe active high, none in halt, independent of control inputs
// - cascade address gate active high, only in acknowledge cycles, no control input
// - transceiver enable active high, postponed for writes in compatible timing mode
// - direction high for writes, low for reads, independent of control inputs
// - transceiver enable is inactive whenever direction changes level
// - direction held high when no bus cycle is in progress
// - strobes active low; timing select and hold-off set assert, ready sets release
// - each cycle type except idle and halt asserts its own strobe
// - decode space select and status; idle and halt issue nothing
// - status and command states each last two clocks; idle lasts until a status code starts a cycle
// - ready sampled at end of command state: high repeats, low ends cycle
package bcc_pkg;

    // ------------------------------------------------------------
    // decoded bus cycle types {space, status_hi_n, status_lo_n}
    // ------------------------------------------------------------
    localparam logic [2:0] CYC_ACK    = 3'h0;
    localparam logic [2:0] CYC_IO_RD  = 3'h1;
    localparam logic [2:0] CYC_IO_WR  = 3'h2;
    localparam logic [2:0] CYC_HALT   = 3'h4;
    localparam logic [2:0] CYC_MEM_RD = 3'h5;
    localparam logic [2:0] CYC_MEM_WR = 3'h6;
    localparam logic [2:0] CYC_IDLE   = 3'h7;   // no cycle, held after reset

    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    localparam int          PHASES_PER_STATE = 2;       // clocks per bus state
    localparam int          SYNC_STAGES      = 2;
    localparam logic [4:0]  STROBE_IDLE      = 5'h1f;   // all strobes inactive high
    localparam logic        DIR_IDLE         = 1'b1;

    // bus state machine, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_STATUS = 3'b010,
        ST_CMD    = 3'b100
    } bcc_state_t;

endpackage

// ==== verilog/bcc_sync.sv ====
// two-stage synchroniser for an asynchronous level
`timescale 1ns/1ps
module bcc_sync #(
    parameter int STAGES = 2
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // level in and out
    input  wire logic d_async,
    output logic      q_sync
);
    initial begin
        if (STAGES < 2) $error("bcc_sync needs at least two stages");
    end

    logic [STAGES-1:0] chain_r;
    logic [STAGES-1:0] chain_nxt;

    // shift the level through the chain
    always_comb begin
        chain_nxt = {chain_r[STAGES-2:0], d_async};
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chain_r <= '0;
        end else begin
            chain_r <= chain_nxt;
        end
    end

    assign q_sync = chain_r[STAGES-1];
endmodule

// ==== verification/bcc_chk.sv ====
// checker: timing relations on the command stage ports
`timescale 1ns/1ps
module bcc_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // inputs watched
    input wire logic compat_timing_select,
    input wire logic space_select,
    input wire logic status_hi_n,
    input wire logic status_lo_n,
    input wire logic gate_or_grant_pin,
    // outputs watched
    input wire logic io_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic mem_write_strobe_n,
    input wire logic mem_read_strobe_n,
    input wire logic irq_ack_strobe_n,
    input wire logic cmd_oe,
    input wire logic addr_latch_strobe,
    input wire logic cascade_addr_gate,
    input wire logic xcvr_on,
    input wire logic xcvr_dir
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // strobes as one vector, cycle code as driven by the master
    wire logic [4:0] stb = {io_write_strobe_n, io_read_strobe_n, mem_write_strobe_n, mem_read_strobe_n, irq_ack_strobe_n};
    wire logic [2:0] cyc = {space_select, status_hi_n, status_lo_n};
    // true for codes that start a real transfer
    function automatic logic live(input logic [2:0] c);
        return c[1:0] != 2'h3 && c != bcc_pkg::CYC_HALT;
    endfunction
    // mode and pin held long enough to pass the synchroniser and output flop
    sequence s_pin(m, v);
        (compat_timing_select == m && gate_or_grant_pin == v) [*3];
    endsequence
    property p_grant_off; s_pin(1'b1, 1'b1) |=> !cmd_oe && !xcvr_on && stb == 5'h1f; endproperty
    a_grant_off: assert property (p_grant_off) else $error("outputs active without grant");
    property p_grant_on; s_pin(1'b1, 1'b0) |=> cmd_oe; endproperty
    a_grant_on: assert property (p_grant_on) else $error("strobes not driven with grant");
    property p_gate_low; s_pin(1'b0, 1'b0) |=> cmd_oe && !xcvr_on && stb == 5'h1f; endproperty
    a_gate_low: assert property (p_gate_low) else $error("closed gate not honoured");
    property p_dir_on; $changed(xcvr_dir) |-> !xcvr_on && !$past(xcvr_on); endproperty
    a_dir_on: assert property (p_dir_on) else $error("direction moved with transceiver on");
    property p_ale; addr_latch_strobe |-> live($past(cyc)) || live($past(cyc, 2)); endproperty
    a_ale: assert property (p_ale) else $error("latch strobe without a transfer");
    property p_mce; !irq_ack_strobe_n |-> cascade_addr_gate && !xcvr_dir; endproperty
    a_mce: assert property (p_mce) else $error("acknowledge without cascade gate");
    property p_wr; !(io_write_strobe_n && mem_write_strobe_n) |-> xcvr_dir; endproperty
    a_wr: assert property (p_wr) else $error("write strobe with read direction");
    property p_rd; !(io_read_strobe_n && mem_read_strobe_n && irq_ack_strobe_n) |-> !xcvr_dir; endproperty
    a_rd: assert property (p_rd) else $error("read strobe with write direction");
    property p_one; $onehot0(~stb); endproperty
    a_one: assert property (p_one) else $error("more than one strobe active");
endmodule
bind bcc_top bcc_chk u_chk (.clk_sys, .srst, .compat_timing_select, .space_select, .status_hi_n,
    .status_lo_n, .gate_or_grant_pin, .io_write_strobe_n, .io_read_strobe_n, .mem_write_strobe_n,
    .mem_read_strobe_n, .irq_ack_strobe_n, .cmd_oe, .addr_latch_strobe, .cascade_addr_gate, .xcvr_on, .xcvr_dir);

// ==== verification/bcc_bus_master.sv ====
// local bus master model: one bus cycle per start pulse
`timescale 1ns/1ps
module bcc_bus_master (
    // clock and reset
    input wire logic  clk_sys,
    input wire logic  srst,
    // request from the bench
    input wire logic  start,
    input wire logic  [2:0] cyc,
    input wire logic  [1:0] waits,
    // local bus side
    output logic      space_select,
    output logic      status_hi_n,
    output logic      status_lo_n,
    output logic      ready_n,
    output logic      busy
);
    int n;
    assign busy = n != 0;
    // status for two clocks, ready held high across the wait states, then low
    always @(posedge clk_sys) begin
        if (srst) begin
            n <= 0;
            {space_select, status_hi_n, status_lo_n} <= 3'h3;
            ready_n <= 1'b0; // low in reset forces idle
        end else if (start && n == 0) begin
            n <= 1;
            {space_select, status_hi_n, status_lo_n} <= cyc;
            ready_n <= 1'b1;
        end else if (n != 0) begin
            n <= (n == 8 + 2 * waits) ? 0 : n + 1;
            if (n == 2) begin
                {status_hi_n, status_lo_n} <= 2'h3;
                space_select <= ~space_select; // unqualified, shows the inverse
            end
            if (n == 2 + 2 * waits) ready_n <= 1'b0;
        end
    end
endmodule

// ==== verification/tb_top.sv ====
// bench: directed scenarios for the bus command control output stage
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic compat_timing_select = 1'b0;
    logic controller_select_latched = 1'b1;
    logic command_hold_off = 1'b0;
    logic gate_or_grant_pin = 1'b1;
    logic start = 1'b0;
    logic [2:0] cyc = 3'h3;
    logic [1:0] waits = 2'h0;
    wire logic space_select, status_hi_n, status_lo_n, ready_n, busy, cmd_oe, addr_latch_strobe;
    wire logic cascade_addr_gate, xcvr_on, xcvr_dir, io_write_strobe_n, io_read_strobe_n;
    wire logic mem_write_strobe_n, mem_read_strobe_n, irq_ack_strobe_n;
    wire logic [4:0] stb = {io_write_strobe_n, io_read_strobe_n, mem_write_strobe_n, mem_read_strobe_n, irq_ack_strobe_n};
    logic [4:0] acc;
    logic s_ale, s_mce, s_on, s_rd, s_oe;
    int err_count = 0, checks = 0, cycles = 0, n_low, f_on;
    bcc_top DUT (.clk_sys, .srst, .compat_timing_select, .space_select, .status_hi_n, .status_lo_n,
        .controller_select_latched, .command_hold_off, .ready_n, .gate_or_grant_pin, .io_write_strobe_n,
        .io_read_strobe_n, .mem_write_strobe_n, .mem_read_strobe_n, .irq_ack_strobe_n, .cmd_oe,
        .addr_latch_strobe, .cascade_addr_gate, .xcvr_on, .xcvr_dir);
    bcc_bus_master u_master (.clk_sys, .srst, .start, .cyc, .waits, .space_select, .status_hi_n,
        .status_lo_n, .ready_n, .busy);
    // 100 ns system clock
    initial forever #50 clk_sys = ~clk_sys;
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d, checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // reset with the strap set, idle levels checked while held
    task automatic do_reset(input logic m);
        @(posedge clk_sys);
        srst <= 1'b1;
        compat_timing_select <= m;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        check({stb, cmd_oe, addr_latch_strobe, cascade_addr_gate, xcvr_on, xcvr_dir}, 10'h3e1);
        @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // one bus cycle, outputs gathered at falling edges
    task automatic run(input logic [2:0] c, input logic [1:0] w);
        @(posedge clk_sys);
        cyc <= c;
        waits <= w;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        acc = 5'h1f;
        {s_ale, s_mce, s_on, s_rd, s_oe} = 5'h00;
        n_low = 0;
        f_on = 99;
        for (int i = 0; i < 40 && (i < 2 || busy); i++) begin
            @(negedge clk_sys);
            acc &= stb;
            {s_ale, s_mce, s_on, s_oe} |= {addr_latch_strobe, cascade_addr_gate, xcvr_on, cmd_oe};
            s_rd |= !xcvr_dir;
            n_low += int'(stb != 5'h1f);
            if (xcvr_on && f_on == 99) f_on = i;
        end
        @(posedge clk_sys);
    endtask
    // every status code in short mode with the gate open
    task automatic t_types();
        logic [4:0] e [8] = '{5'h1e, 5'h17, 5'h0f, 5'h1f, 5'h1f, 5'h1d, 5'h1b, 5'h1f};
        logic act;
        for (int i = 0; i < 8; i++) begin
            act = i[1:0] != 2'h3 && i[2:0] != bcc_pkg::CYC_HALT;
            run(i[2:0], 2'h0);
            check(acc, e[i]);
            check(s_ale, act);
            check(s_on, act);
            check(s_rd, act && !i[1]);
            check(s_mce, i[2:0] == bcc_pkg::CYC_ACK);
        end
    endtask
    // closed gate, unselected, held off and wait states in short mode
    task automatic t_short();
        int n0;
        gate_or_grant_pin <= 1'b0;
        run(bcc_pkg::CYC_MEM_RD, 2'h0);
        check({acc, s_on, s_oe, s_ale}, {5'h1f, 3'h3});
        gate_or_grant_pin <= 1'b1;
        controller_select_latched <= 1'b0;
        run(bcc_pkg::CYC_IO_RD, 2'h0);
        check({acc, s_on, s_ale, s_rd}, {5'h1f, 3'h3});
        controller_select_latched <= 1'b1;
        command_hold_off <= 1'b1;
        run(bcc_pkg::CYC_MEM_RD, 2'h0);
        check(acc, 5'h1f);
        command_hold_off <= 1'b0;
        run(bcc_pkg::CYC_MEM_WR, 2'h0);
        n0 = n_low;
        check(n0, 2);
        run(bcc_pkg::CYC_MEM_WR, 2'h2);
        check(n_low - n0, 4);
    endtask
    // compatible timing: grant gives drive, writes open the transceiver late
    task automatic t_compat();
        int f_rd;
        gate_or_grant_pin <= 1'b0;
        do_reset(1'b1);
        run(bcc_pkg::CYC_MEM_RD, 2'h1);
        f_rd = f_on;
        check({acc, s_oe, n_low[3:0]}, {5'h1d, 1'b1, 4'h2});
        run(bcc_pkg::CYC_IO_WR, 2'h1);
        check({acc, f_on > f_rd}, {5'h0f, 1'b1});
        gate_or_grant_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        run(bcc_pkg::CYC_MEM_WR, 2'h1);
        check({acc, s_oe, s_on}, {5'h1f, 2'h0});
    endtask
    // main sequence
    initial begin
        do_reset(1'b0);
        t_types();
        t_short();
        t_compat();
        end_of_test();
    end
    // cycle ceiling in case a transfer never ends
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end
endmodule
